// File: pma_core.sv
// Program counter, return stack, shadow context and indirect pointers.
// Assumes a flash array answering one cycle after its read strobe and a
// data memory answering in the same cycle as its read strobe.
`timescale 1ns/1ps
module pma_core
	import pma_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        cmd_valid,
	input  wire logic [3:0]  cmd_op,
	input  wire logic [14:0] cmd_target,
	input  wire logic [7:0]  cmd_literal,
	input  wire logic        cmd_ptr_sel,
	input  wire logic [15:0] cmd_ptr_value,
	input  wire logic [7:0]  cmd_wdata,
	output logic             cmd_ready,
	output logic             cmd_done,
	output logic [14:0]      pc,
	output logic [7:0]       work,
	output logic             soft_reset,
	output logic [14:0]      pmem_addr,
	output logic             pmem_rd,
	output logic             pmem_he,
	input  wire logic [13:0] pmem_rdata,
	output logic [11:0]      dmem_addr,
	output logic             dmem_rd,
	output logic             dmem_wr,
	output logic [7:0]       dmem_wdata,
	input  wire logic [7:0]  dmem_rdata,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq
);
	// ****************************************
	// State
	// ****************************************
	pma_st_t     st_q;
	pma_st_t     st_d;
	logic        acc;
	logic [15:0] sel_ptr;
	logic        sel_pmem;
	logic        bus_wr;
	logic        push_req;
	logic        pop_req;
	logic [14:0] push_val;
	logic [EV_N-1:0] ev_set;
	logic        fault;

	assign acc      = cmd_valid && st_q.cmd_ready;
	assign sel_ptr  = st_q.ptr[cmd_ptr_sel];
	assign sel_pmem = sel_ptr[PMEM_SEL_BIT];
	// A write lands only at the edge where the master sees waitrequest low
	assign bus_wr   = avs_write && st_q.wait_n;

	// Linear window folds onto the general purpose part of each bank
	function automatic logic [11:0] data_map(input logic [15:0] p);
		logic [11:0] off;
		logic [11:0] bank;
		logic [11:0] idx;
		off  = 12'(p - LIN_BASE);
		bank = off / LIN_BANK_SZ;
		idx  = off % LIN_BANK_SZ;
		if (p >= LIN_BASE && p <= LIN_LAST) begin
			data_map = {bank[4:0], 7'(GPR_FIRST + idx[6:0])};
		end else begin
			data_map = p[11:0];
		end
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		be_merge = r;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_d          = st_q;
		st_d.cmd_done = 1'b0;
		st_d.soft_reset = 1'b0;
		st_d.pmem_rd  = 1'b0;
		st_d.dmem_rd  = 1'b0;
		st_d.dmem_wr  = 1'b0;
		push_req      = 1'b0;
		pop_req       = 1'b0;
		push_val      = '0;
		ev_set        = '0;
		fault         = 1'b0;

		// Bus side writes first so that the core wins on a collision
		if (bus_wr) begin
			case (avs_address)
				OFS_CTRL: begin
					if (avs_byteenable[0]) begin
						st_d.fault_rst_en = avs_writedata[0];
					end
				end
				OFS_POWER_CONTROL_STATUS_REG: begin
					if (avs_byteenable[0]) begin
						st_d.ovf = avs_writedata[0];
						st_d.unf = avs_writedata[1];
					end
				end
				OFS_IRQ_CLR: begin
					if (avs_byteenable[0]) begin
						st_d.ev_stat = st_q.ev_stat & ~avs_writedata[EV_N-1:0];
					end
				end
				OFS_IRQ_EN: begin
					if (avs_byteenable[0]) begin
						st_d.ev_en = avs_writedata[EV_N-1:0];
					end
				end
				OFS_PTR0: begin
					st_d.ptr[0] = 16'(be_merge(32'(st_q.ptr[0]), avs_writedata, avs_byteenable));
				end
				OFS_PTR1: begin
					st_d.ptr[1] = 16'(be_merge(32'(st_q.ptr[1]), avs_writedata, avs_byteenable));
				end
				default: begin
				end
			endcase
		end

		case (st_q.state)
			ST_IDLE: begin
				if (acc) begin
					st_d.cmd_done = 1'b1;
					case (pma_op_t'(cmd_op))
						OP_STEP: begin
							st_d.pc = (st_q.pc + 15'h0001) & PC_MASK;
						end
						OP_JUMP: begin
							st_d.pc = cmd_target & PC_MASK;
						end
						OP_CALL: begin
							push_req = 1'b1;
							push_val = (st_q.pc + 15'h0001) & PC_MASK;
							st_d.pc  = cmd_target & PC_MASK;
						end
						OP_RET: begin
							pop_req = 1'b1;
						end
						OP_RETURN_WITH_LITERAL: begin
							pop_req   = 1'b1;
							st_d.work = cmd_literal;
						end
						OP_RETFIE: begin
							pop_req   = 1'b1;
							st_d.work = st_q.sh_work;
							st_d.ptr  = st_q.sh_ptr;
						end
						OP_BRW: begin
							st_d.pc = (st_q.pc + 15'h0001 + 15'(st_q.work)) & PC_MASK;
						end
						OP_IRQ: begin
							push_req     = 1'b1;
							push_val     = st_q.pc;
							st_d.pc      = IRQ_VECTOR;
							st_d.sh_work = st_q.work;
							st_d.sh_ptr  = st_q.ptr;
						end
						OP_IND_RD: begin
							st_d.cmd_done = 1'b0;
							st_d.cmd_ready = 1'b0;
							if (sel_pmem) begin
								st_d.pmem_addr = {sel_ptr[14:8], sel_ptr[7:0]};
								st_d.pmem_he   = ({sel_ptr[14:8], sel_ptr[7:0]} & PC_MASK) >= HE_FIRST;
								st_d.pmem_rd   = 1'b1;
								st_d.state     = ST_PRD1;
							end else begin
								st_d.dmem_addr = data_map(sel_ptr);
								st_d.dmem_rd   = 1'b1;
								st_d.state     = ST_DRD;
							end
						end
						OP_IND_WR: begin
							if (sel_pmem) begin
								ev_set[2] = 1'b1;
							end else begin
								st_d.dmem_addr  = data_map(sel_ptr);
								st_d.dmem_wdata = cmd_wdata;
								st_d.dmem_wr    = 1'b1;
							end
						end
						OP_PTR_LD: begin
							st_d.ptr[cmd_ptr_sel] = cmd_ptr_value;
						end
						default: begin
						end
					endcase
				end
			end
			ST_DRD: begin
				st_d.work      = dmem_rdata;
				st_d.cmd_done  = 1'b1;
				st_d.cmd_ready = 1'b1;
				st_d.state     = ST_IDLE;
			end
			ST_PRD1: begin
				// Flash answers one cycle after the strobe; this is the extra cycle
				st_d.state = ST_PRD2;
			end
			ST_PRD2: begin
				st_d.work      = pmem_rdata[7:0];
				st_d.cmd_done  = 1'b1;
				st_d.cmd_ready = 1'b1;
				st_d.pmem_he   = 1'b0;
				st_d.state     = ST_IDLE;
			end
			default: begin
				st_d.state     = ST_IDLE;
				st_d.cmd_ready = 1'b1;
			end
		endcase

		// Return stack; a full push drops the value rather than overwrite
		if (push_req) begin
			if (st_q.sp == 5'(STACK_DEPTH)) begin
				st_d.ovf  = 1'b1;
				ev_set[0] = 1'b1;
				fault     = 1'b1;
			end else begin
				st_d.stack[st_q.sp[3:0]] = push_val;
				st_d.sp = st_q.sp + 5'h01;
			end
		end
		if (pop_req) begin
			if (st_q.sp == 5'h00) begin
				st_d.unf  = 1'b1;
				ev_set[1] = 1'b1;
				fault     = 1'b1;
			end else begin
				st_d.pc = st_q.stack[4'(st_q.sp - 5'h01)];
				st_d.sp = st_q.sp - 5'h01;
			end
		end
		if (fault && st_q.fault_rst_en) begin
			st_d.soft_reset = 1'b1;
			st_d.pc         = RESET_VECTOR;
			st_d.sp         = '0;
		end

		// Sticky events; a set in the clearing cycle survives
		st_d.ev_stat = st_d.ev_stat | ev_set;
		st_d.irq     = |(st_d.ev_stat & st_d.ev_en);

		// Avalon slave: one wait cycle, then a single ready cycle
		if ((avs_read || avs_write) && !st_q.wait_n) begin
			st_d.wait_n = 1'b1;
			st_d.rdata  = '0;
			if (avs_read) begin
				case (avs_address)
					OFS_CTRL:   st_d.rdata = 32'(st_q.fault_rst_en);
					OFS_POWER_CONTROL_STATUS_REG:   st_d.rdata = {30'h0, st_q.unf, st_q.ovf};
					OFS_IRQ_ST: st_d.rdata = 32'(st_q.ev_stat);
					OFS_IRQ_EN: st_d.rdata = 32'(st_q.ev_en);
					OFS_PTR0:   st_d.rdata = 32'(st_q.ptr[0]);
					OFS_PTR1:   st_d.rdata = 32'(st_q.ptr[1]);
					OFS_PC:     st_d.rdata = 32'(st_q.pc);
					OFS_WORK:   st_d.rdata = 32'(st_q.work);
					OFS_SP:     st_d.rdata = 32'(st_q.sp);
					default:    st_d.rdata = '0;
				endcase
			end
		end else begin
			st_d.wait_n = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign cmd_ready       = st_q.cmd_ready;
	assign cmd_done        = st_q.cmd_done;
	assign pc              = st_q.pc;
	assign work            = st_q.work;
	assign soft_reset      = st_q.soft_reset;
	assign pmem_addr       = st_q.pmem_addr;
	assign pmem_rd         = st_q.pmem_rd;
	assign pmem_he         = st_q.pmem_he;
	assign dmem_addr       = st_q.dmem_addr;
	assign dmem_rd         = st_q.dmem_rd;
	assign dmem_wr         = st_q.dmem_wr;
	assign dmem_wdata      = st_q.dmem_wdata;
	assign avs_readdata    = st_q.rdata;
	assign avs_waitrequest = !st_q.wait_n;
	assign irq             = st_q.irq;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_stack_depth_bound: assert property (st_q.sp <= 5'(STACK_DEPTH))
		else $error("stack pointer past depth");
	a_overflow_on_full: assert property (acc && pma_op_t'(cmd_op) == OP_CALL && st_q.sp == 5'h10
		|=> st_q.ovf) else $error("overflow flag not set");
	a_underflow_on_empty: assert property (acc && pma_op_t'(cmd_op) == OP_RET && st_q.sp == 5'h00
		|=> st_q.unf) else $error("underflow flag not set");
	a_fault_reset_gate: assert property (soft_reset |-> $past(st_q.fault_rst_en) && (st_q.ovf || st_q.unf))
		else $error("soft reset without enabled fault");
	a_pc_wraps_low: assert property (pc[14:11] == 4'h0)
		else $error("program counter outside implemented space");
	a_irq_vector_jump: assert property (acc && pma_op_t'(cmd_op) == OP_IRQ && st_q.sp != 5'h10
		|=> pc == IRQ_VECTOR) else $error("interrupt did not vector");
	a_pmem_extra_cycle: assert property (acc && pma_op_t'(cmd_op) == OP_IND_RD && sel_pmem
		|=> pmem_rd && !cmd_done ##1 !cmd_done ##1 cmd_done) else $error("program read timing");
	a_pmem_addr_form: assert property (acc && pma_op_t'(cmd_op) == OP_IND_RD && sel_pmem
		|=> pmem_addr == $past(sel_ptr[14:0])) else $error("program address wrong");
	a_low_byte_load: assert property (st_q.state == ST_PRD2 |=> work == $past(pmem_rdata[7:0]))
		else $error("working register not low byte");
	a_no_pmem_write: assert property (acc && pma_op_t'(cmd_op) == OP_IND_WR && sel_pmem
		|=> !dmem_wr && st_q.ev_stat[2]) else $error("program write leaked");
	a_return_with_literal_literal: assert property (acc && pma_op_t'(cmd_op) == OP_RETURN_WITH_LITERAL
		|=> work == $past(cmd_literal)) else $error("literal not loaded");

	c_overflow_seen: cover property (st_q.ovf && !$past(st_q.ovf));
	c_pmem_read_done: cover property (st_q.state == ST_PRD2 ##1 cmd_done);
	c_irq_then_retfie: cover property (acc && pma_op_t'(cmd_op) == OP_IRQ ##[1:20]
		acc && pma_op_t'(cmd_op) == OP_RETFIE);
	c_bus_read_done: cover property (avs_read && !avs_waitrequest);
endmodule

// File: pma_pkg.sv
// Constants, types and reset state for the program memory access block.
// Assumes one 200 MHz clock and an asynchronous active-high reset.
// Notes on behaviour
// - Return stack holds sixteen entries of fifteen bits each.
// - Push when full sets overflow flag; pop when empty sets underflow flag.
// - With fault reset enabled, a stack fault also requests a software reset.
// - Two independent 16-bit pointers reach data and program memory in one range.
// - Indirect access to program memory costs one extra cycle for the fetch.
// - General purpose RAM is reachable as one linear contiguous region.
// - Program counter is 15 bits; program words are 14 bits.
// - Program counter addresses above 07FFh wrap onto the 2048 implemented words; pmem_addr passes all 15 pointer bits unwrapped.
// - Reset starts at 0000h; accepted interrupt jumps to 0004h.
// - Words 0780h to 07FFh are high endurance, low byte only.
// - Pointer high byte bit 7 set selects program memory for indirect access.
// - Indirect program read loads only the low eight bits into working register.
// - Indirect writes aimed at program memory change no memory; they only set event bit 2.
// - Interrupt entry saves context to shadows; return restores it without stack.
// - Return with literal pops into counter and loads literal into working register.
package pma_pkg;
	// ****************************************
	// Sizes and vectors
	// ****************************************
	localparam int          PC_W         = 15;
	localparam int          STACK_DEPTH  = 16;
	localparam int          SP_W         = 5;
	localparam int          WORD_W       = 14;
	localparam logic [14:0] PC_MASK      = 15'h07FF;
	localparam logic [14:0] RESET_VECTOR = 15'h0000;
	localparam logic [14:0] IRQ_VECTOR   = 15'h0004;
	localparam logic [14:0] HE_FIRST     = 15'h0780;
	localparam logic [14:0] HE_LAST      = 15'h07FF;
	localparam int          PMEM_SEL_BIT = 15;
	localparam logic [15:0] LIN_BASE     = 16'h2000;
	localparam logic [15:0] LIN_LAST     = 16'h29AF;
	localparam logic [11:0] LIN_BANK_SZ  = 12'h050;
	localparam logic [6:0]  GPR_FIRST    = 7'h20;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_POWER_CONTROL_STATUS_REG    = 8'h04;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
	localparam logic [7:0] OFS_PTR0    = 8'h14;
	localparam logic [7:0] OFS_PTR1    = 8'h18;
	localparam logic [7:0] OFS_PC      = 8'h1C;
	localparam logic [7:0] OFS_WORK    = 8'h20;
	localparam logic [7:0] OFS_SP      = 8'h24;
	// Event bits: 0 overflow, 1 underflow, 2 blocked program write
	localparam int         EV_N        = 3;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		OP_STEP   = 4'h0,
		OP_JUMP   = 4'h1,
		OP_CALL   = 4'h2,
		OP_RET    = 4'h3,
		OP_RETURN_WITH_LITERAL  = 4'h4,
		OP_RETFIE = 4'h5,
		OP_BRW    = 4'h6,
		OP_IRQ    = 4'h7,
		OP_IND_RD = 4'h8,
		OP_IND_WR = 4'h9,
		OP_PTR_LD = 4'hA
	} pma_op_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DRD  = 4'b0010,
		ST_PRD1 = 4'b0100,
		ST_PRD2 = 4'b1000
	} pma_state_t;
	typedef struct packed {
		pma_state_t                   state;
		logic [14:0]                  pc;
		logic [7:0]                   work;
		logic [1:0][15:0]             ptr;
		logic [STACK_DEPTH-1:0][14:0] stack;
		logic [4:0]                   sp;
		logic                         ovf;
		logic                         unf;
		logic [7:0]                   sh_work;
		logic [1:0][15:0]             sh_ptr;
		logic                         fault_rst_en;
		logic [EV_N-1:0]              ev_stat;
		logic [EV_N-1:0]              ev_en;
		logic                         irq;
		logic                         cmd_ready;
		logic                         cmd_done;
		logic                         soft_reset;
		logic [14:0]                  pmem_addr;
		logic                         pmem_rd;
		logic                         pmem_he;
		logic [11:0]                  dmem_addr;
		logic                         dmem_rd;
		logic                         dmem_wr;
		logic [7:0]                   dmem_wdata;
		logic                         wait_n;
		logic [31:0]                  rdata;
	} pma_st_t;
	localparam pma_st_t ST_RESET = '{state: ST_IDLE, cmd_ready: 1'b1, default: '0};
endpackage

// File: pma_flash_model.sv
// Behavioural flash array on the far side of the program read port.
// Assumes the core strobes pmem_rd for one cycle and samples data the next cycle.
`timescale 1ns/1ps
module pma_flash_model (
	input  wire logic        clk,
	input  wire logic        pmem_rd,
	input  wire logic [14:0] pmem_addr,
	output logic      [13:0] pmem_rdata
);
	// ****************************************
	// Array content and answer timing
	// ****************************************
	logic [13:0] word_q;
	logic        vld_q;
	initial begin
		word_q = '0;
		vld_q  = 1'b0;
	end
	// Content is a fixed function of the address; the address itself is checked separately
	always @(posedge clk) begin
		vld_q <= pmem_rd;
		if (pmem_rd) begin
			word_q <= {pmem_addr[5:0], pmem_addr[7:0]} ^ 14'h2D69;
		end
	end
	// Outside the answer cycle the line shows the inverse, never a stale valid word
	assign pmem_rdata = vld_q ? word_q : ~word_q;
endmodule

// File: cpu_program_memory_access_tb.sv
// Self-checking bench for the program memory access core with a reference model.
// Assumes pma_pkg, pma_core and pma_flash_model are compiled first.
`timescale 1ns/1ps
module cpu_program_memory_access_tb;
	import pma_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk, sys_rst, cmd_valid, cmd_ptr_sel, cmd_ready, cmd_done, soft_reset;
	logic [3:0]  cmd_op, avs_byteenable;
	logic [14:0] cmd_target, pc, pmem_addr;
	logic [7:0]  cmd_literal, cmd_wdata, work, dmem_wdata, dmem_rdata, avs_address, cyc, cap_dw;
	logic [15:0] cmd_ptr_value;
	logic        pmem_rd, pmem_he, dmem_rd, dmem_wr, avs_read, avs_write, avs_waitrequest, irq, cap_he;
	logic [13:0] pmem_rdata;
	logic [11:0] dmem_addr, cap_da;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [14:0] cap_pa;
	int          miscompares, n_compared, n_soft, n_dwr, seed;
	int          m_pc, m_work, m_ev, m_fre, m_sx, m_dwr, ms_w;
	int          mp[2], ms_p[2];
	int          m_stk[$];
	pma_core i_pma_core (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_target(cmd_target), .cmd_literal(cmd_literal), .cmd_ptr_sel(cmd_ptr_sel),
		.cmd_ptr_value(cmd_ptr_value), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
		.pc(pc), .work(work), .soft_reset(soft_reset), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
		.pmem_he(pmem_he), .pmem_rdata(pmem_rdata), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
		.dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq));
	pma_flash_model i_pma_flash_model (.clk(clk), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr),
		.pmem_rdata(pmem_rdata));
	// Data memory answers in the strobe cycle; otherwise a moving pattern so nothing stale passes
	assign dmem_rdata = dmem_rd ? (dmem_addr[7:0] ^ 8'hC3) : cyc;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 8'h01;
		if (pmem_rd) begin
			cap_pa = pmem_addr;
			cap_he = pmem_he;
		end
		if (dmem_rd || dmem_wr) cap_da = dmem_addr;
		if (dmem_wr) begin
			n_dwr++;
			cap_dw = dmem_wdata;
		end
		if (soft_reset) n_soft++;
	end
	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_sim();
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo();
		miscompares++;
		end_sim();
	endtask
	function automatic int fw(input logic [14:0] a);
		return {a[5:0], a[7:0]} ^ 14'h2D69;
	endfunction
	function automatic int dmap(input logic [15:0] p);
		int o;
		o = p - 16'h2000;
		if (p >= 16'h2000 && p <= 16'h29AF) return (o / 80) * 128 + 32 + o % 80;
		return p[11:0];
	endfunction
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge clk);
		avs_address    <= a;
		avs_write      <= wr;
		avs_read       <= !wr;
		avs_writedata  <= d;
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (n >= 50) tmo();
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk("readdata", e, q);
	endtask
	// One core command; the model is stepped alongside and compared at completion
	task automatic cmd(input pma_op_t op, input logic [14:0] tg, input logic [7:0] lit,
		input logic sel, input logic [15:0] val);
		int n, lat, r;
		lat = 1;
		@(posedge clk);
		cmd_valid     <= 1'b1;
		cmd_op        <= op;
		cmd_target    <= tg;
		cmd_literal   <= lit;
		cmd_ptr_sel   <= sel;
		cmd_ptr_value <= val;
		cmd_wdata     <= lit;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 50);
		if (n >= 50) tmo();
		cmd_valid <= 1'b0;
		case (op)
			OP_STEP: m_pc = (m_pc + 1) & 'h7FF;
			OP_JUMP: m_pc = tg & 'h7FF;
			OP_BRW: m_pc = (m_pc + 1 + m_work) & 'h7FF;
			OP_CALL, OP_IRQ: begin
				r = (op == OP_IRQ) ? m_pc : (m_pc + 1) & 'h7FF;
				if (op == OP_IRQ) begin
					ms_w = m_work;
					ms_p = mp;
				end
				m_pc = (op == OP_IRQ) ? 4 : tg & 'h7FF;
				if (m_stk.size() < 16) m_stk.push_back(r);
				else begin
					m_ev |= 1;
					if (m_fre) begin
						m_pc = 0;
						m_stk.delete();
						m_sx++;
					end
				end
			end
			OP_RET, OP_RETURN_WITH_LITERAL, OP_RETFIE: begin
				if (m_stk.size() > 0) m_pc = m_stk.pop_back();
				else begin
					m_ev |= 2;
					if (m_fre) begin
						m_pc = 0;
						m_sx++;
					end
				end
				if (op == OP_RETURN_WITH_LITERAL) m_work = lit;
				if (op == OP_RETFIE) begin
					m_work = ms_w;
					mp = ms_p;
				end
			end
			OP_IND_RD: begin
				lat = mp[sel][15] ? 3 : 2;
				m_work = mp[sel][15] ? fw(mp[sel][14:0]) & 'hFF : (dmap(mp[sel]) ^ 'hC3) & 'hFF;
			end
			OP_IND_WR: if (mp[sel][15]) m_ev |= 4; else m_dwr++;
			default: mp[sel] = val;
		endcase
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cmd_done !== 1'b1 && n < 50);
		if (n >= 50) tmo();
		chk("latency", lat, n);
		chk("pc", m_pc, pc);
		chk("work", m_work, work);
		// Strobes stand in the cycle of cmd_done; the counters see them at the next edge
		@(negedge clk);
		chk("soft_reset", m_sx, n_soft);
		chk("dmem_wr", m_dwr, n_dwr);
		if (op == OP_IND_WR && !mp[sel][15]) begin
			chk("dmem_addr", dmap(mp[sel]), cap_da);
			chk("dmem_wdata", lit, cap_dw);
		end
		if (op == OP_IND_RD && mp[sel][15]) begin
			chk("pmem_addr", mp[sel][14:0], cap_pa);
			chk("pmem_he", (mp[sel] & 'h7FF) >= 'h780, cap_he);
		end
		if (op == OP_IND_RD && !mp[sel][15]) chk("dmem_addr", dmap(mp[sel]), cap_da);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{cmd_valid, cmd_op, cmd_target, cmd_literal, cmd_ptr_sel, cmd_ptr_value, cmd_wdata} = '0;
		{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
		{miscompares, n_compared, n_soft, n_dwr, m_pc, m_work, m_ev, m_fre, m_sx, m_dwr} = '0;
		mp = '{0, 0};
		cyc = 8'h00;
		seed = 32'hcf7b;
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk("pc", 0, pc);
		chk("irq", 0, irq);
		rchk(OFS_CTRL, 32'h0);
		rchk(8'h40, 32'h0);
		bus(1'b1, OFS_PC, 32'h0000_0123, 4'hF);
		rchk(OFS_PC, 32'h0);
		bus(1'b1, OFS_PTR1, 32'hFFFF_BEEF, 4'h1);
		mp[1] = 'hEF;
		rchk(OFS_PTR1, 32'h0000_00EF);
		for (int i = 0; i < 6; i++) cmd(OP_JUMP, 15'($random(seed)), 8'h00, 1'b0, 16'h0);
		cmd(OP_JUMP, 15'h7FFF, 8'h00, 1'b0, 16'h0);
		cmd(OP_STEP, 15'h0, 8'h00, 1'b0, 16'h0);
		for (int i = 0; i < 17; i++) cmd(OP_CALL, 15'($random(seed)), 8'h00, 1'b0, 16'h0);
		rchk(OFS_SP, 32'd16);
		rchk(OFS_POWER_CONTROL_STATUS_REG, 32'h1);
		for (int i = 0; i < 17; i++) cmd(OP_RET, 15'h0, 8'h00, 1'b0, 16'h0);
		rchk(OFS_POWER_CONTROL_STATUS_REG, 32'h3);
		rchk(OFS_IRQ_ST, 32'(m_ev));
		bus(1'b1, OFS_IRQ_EN, 32'h7, 4'hF);
		repeat (2) @(negedge clk);
		chk("irq", 1, irq);
		bus(1'b1, OFS_IRQ_CLR, 32'h3, 4'hF);
		m_ev = 0;
		repeat (2) @(negedge clk);
		chk("irq", 0, irq);
		// Fault reset path: an empty pop now also restarts the counter
		bus(1'b1, OFS_CTRL, 32'h1, 4'hF);
		m_fre = 1;
		cmd(OP_RET, 15'h0, 8'h00, 1'b0, 16'h0);
		bus(1'b1, OFS_CTRL, 32'h0, 4'hF);
		m_fre = 0;
		for (int i = 0; i < 8; i++) begin
			automatic logic [14:0] a = (i == 0) ? 15'h0780 : (i == 1) ? 15'h077F : (i == 2) ? 15'h07FF
				: (i == 3) ? 15'h0F80 : 15'($random(seed));
			cmd(OP_PTR_LD, 15'h0, 8'h00, i[0], {1'b1, a});
			cmd(OP_IND_RD, 15'h0, 8'h00, i[0], 16'h0);
		end
		for (int i = 0; i < 3; i++) begin
			cmd(OP_PTR_LD, 15'h0, 8'h00, 1'b1, (i == 0) ? 16'h0025 : (i == 1) ? 16'h2050 : 16'h29AF);
			cmd(OP_IND_RD, 15'h0, 8'h00, 1'b1, 16'h0);
		end
		cmd(OP_PTR_LD, 15'h0, 8'h00, 1'b0, 16'h8100);
		cmd(OP_IND_WR, 15'h0, 8'h5A, 1'b0, 16'h0);
		cmd(OP_IND_WR, 15'h0, 8'h3C, 1'b1, 16'h0);
		rchk(OFS_IRQ_ST, 32'(m_ev));
		cmd(OP_PTR_LD, 15'h0, 8'h00, 1'b0, 16'h1234);
		cmd(OP_PTR_LD, 15'h0, 8'h00, 1'b1, 16'h00EF);
		cmd(OP_JUMP, 15'h0123, 8'h00, 1'b0, 16'h0);
		cmd(OP_IRQ, 15'h0, 8'h00, 1'b0, 16'h0);
		cmd(OP_PTR_LD, 15'h0, 8'h00, 1'b0, 16'h0555);
		cmd(OP_IND_RD, 15'h0, 8'h00, 1'b1, 16'h0);
		cmd(OP_RETFIE, 15'h0, 8'h00, 1'b0, 16'h0);
		rchk(OFS_PTR0, 32'h0000_1234);
		rchk(OFS_SP, 32'd0);
		cmd(OP_JUMP, 15'h0200, 8'h00, 1'b0, 16'h0);
		cmd(OP_CALL, 15'h0300, 8'h00, 1'b0, 16'h0);
		cmd(OP_RETURN_WITH_LITERAL, 15'h0, 8'hA5, 1'b0, 16'h0);
		cmd(OP_BRW, 15'h0, 8'h00, 1'b0, 16'h0);
		cmd(OP_JUMP, 15'h07F0, 8'h00, 1'b0, 16'h0);
		cmd(OP_BRW, 15'h0, 8'h00, 1'b0, 16'h0);
		end_sim();
	end
endmodule
